// file: shared/drb_pkg.sv
// Purpose: shared constants and types of the read burst path
// Assumes: 32-bit register port, x16 data, 8 banks
// Notes:   offsets are byte addresses on the register port
`default_nettype none
package drb_pkg;
    localparam int          DATA_W      = 16;
    localparam int          ADDR_W      = 8;
    localparam int          RING_AW     = 6;
    localparam int          RING_DEPTH  = 64;
    localparam int          SYNC_W      = 8;

    // register offsets
    localparam logic [7:0]  REG_MODE    = 8'h00;
    localparam logic [7:0]  REG_LAT     = 8'h04;
    localparam logic [7:0]  REG_BANK    = 8'h08;
    localparam logic [7:0]  REG_STATUS  = 8'h0C;
    localparam logic [7:0]  REG_COUNT   = 8'h10;

    // field positions
    localparam int          MODE_BL_LSB = 0;
    localparam int          MODE_PRE2   = 2;
    localparam int          LAT_CL_LSB  = 0;
    localparam int          LAT_AL_LSB  = 8;
    localparam int          ST_LOCK     = 0;
    localparam int          ST_BUSY     = 1;
    localparam int          ST_REFUSE   = 2;
    localparam int          ST_UNDER    = 3;

    // burst field encodings
    localparam logic [1:0]  BL_FIX8     = 2'h0;
    localparam logic [1:0]  BL_OTF      = 2'h1;
    localparam logic [1:0]  BL_FIX4     = 2'h2;

    // reset values
    localparam logic [1:0]  BL_RST      = 2'h0;
    localparam logic        PRE2_RST    = 1'h0;
    localparam logic [5:0]  CL_RST      = 6'h0B;
    localparam logic [5:0]  AL_RST      = 6'h00;
    localparam logic [7:0]  BANK_RST    = 8'h00;

    // beats per burst, half clock periods
    localparam logic [3:0]  BEATS_BL8   = 4'h8;
    localparam logic [3:0]  BEATS_BC4   = 4'h4;

    typedef struct packed {
        logic       valid;
        logic       chop;
        logic       autopre;
        logic [2:0] bank;
    } drb_slot_t;

    typedef enum logic [1:0] {
        DRV_IDLE,
        DRV_PRE,
        DRV_DATA,
        DRV_POST
    } drb_drv_t;
endpackage : drb_pkg
`default_nettype wire

// file: rtl/drb_pin_sync.sv
// Purpose: two-flop synchroniser for pins from outside core_clk
// Assumes: bits are independent levels
// Notes:   first stage feeds only the second
`default_nettype none
module drb_pin_sync #(
    parameter int                W       = 8,
    parameter logic [W-1:0]      RST_VAL = '0
) (
    input  wire logic            core_clk,
    input  wire logic            rstn,
    input  wire logic [W-1:0]    pin_in,
    output logic      [W-1:0]    pin_sync
);
    logic [W-1:0] stage1;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            stage1   <= RST_VAL;
            pin_sync <= RST_VAL;
        end else begin
            stage1   <= pin_in;
            pin_sync <= stage1;
        end
    end
endmodule : drb_pin_sync
`default_nettype wire

// file: rtl/drb_beat_fifo.sv
// Purpose: two-entry buffer for read data beats
// Assumes: single clock, push and pop may coincide
// Notes:   in_ready is a flop so back-pressure reaches the source cleanly
`default_nettype none
module drb_beat_fifo #(
    parameter int              W = 16
) (
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic      [W-1:0]  out_data
);
    logic [W-1:0] mem [0:1];
    logic         wr_ptr;
    logic         rd_ptr;
    logic [1:0]   count;

    wire          push       = in_valid & in_ready;
    wire          pop        = out_valid & out_ready;
    wire [1:0]    next_count = 2'(count + {1'b0, push} - {1'b0, pop});

    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr   <= 1'b0;
            rd_ptr   <= 1'b0;
            count    <= 2'h0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count    <= next_count;
            in_ready <= (next_count != 2'h2);
        end
    end
endmodule : drb_beat_fifo
`default_nettype wire

// file: rtl/drb_read_path.sv
// Purpose: read burst path of a x16 DRAM, seen from the memory side
// Assumes: controller clock pin ck is sampled by core_clk (much faster)
// Notes:   one data beat per ck edge; data supplied through a beat stream
`default_nettype none
// Notes on behaviour
// - Reads run as fixed eight-beat, fixed chop-four, or length chosen per command.
// - In per-command mode address bit 12 low gives chop-four and high gives eight beats.
// - A read with address bit 10 low leaves the bank open after the burst.
// - A read with address bit 10 high precharges the bank once the burst completes.
// - Eight beats come from burst field 00 or 11, or field 01 with bit 12 high.
// - Chop-four comes from burst field 10, or field 01 with bit 12 low.
// - Data pins are released at the ck rise RL+4 after an eight-beat read and RL+2 after chop-four.
// - Strobe and data timing only hold with the DLL locked, so reads are refused otherwise.
// - The read strobe preamble is one or two ck cycles, chosen by a mode bit.
// - The read strobe postamble is half a ck cycle whatever the preamble length.
module drb_read_path (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // controller pins
    input  wire logic        ck,
    input  wire logic        rd_cmd_n,
    input  wire logic        addr_a10,
    input  wire logic        addr_a12,
    input  wire logic [2:0]  bank_addr,
    input  wire logic        dll_locked,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic             dq_oe_n,
    input  wire logic        dqs_in,
    output logic             dqs_out,
    output logic             dqs_oe_n,
    // read data source
    input  wire logic        beat_valid,
    output logic             beat_ready,
    input  wire logic [15:0] beat_data
);
    // synchronised pins
    logic [drb_pkg::SYNC_W-1:0] pins_s;
    logic                       ck_d;

    drb_pin_sync #(
        .W       (drb_pkg::SYNC_W),
        .RST_VAL (8'h02)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin_in   ({dll_locked, bank_addr, addr_a12, addr_a10, rd_cmd_n, ck}),
        .pin_sync (pins_s)
    );

    wire       ck_s    = pins_s[0];
    wire       rd_n_s  = pins_s[1];
    wire       a10_s   = pins_s[2];
    wire       a12_s   = pins_s[3];
    wire [2:0] bank_s  = pins_s[6:4];
    wire       lock_s  = pins_s[7];
    wire       ck_rise = ck_s & ~ck_d;
    wire       ck_fall = ~ck_s & ck_d;

    // beat buffer
    logic        buf_valid;
    logic        buf_pop;
    logic [15:0] buf_data;

    drb_beat_fifo #(
        .W (drb_pkg::DATA_W)
    ) u_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (beat_valid),
        .in_ready  (beat_ready),
        .in_data   (beat_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_data)
    );

    function automatic logic [5:0] ring_add(input logic [5:0] a, input logic [5:0] b);
        return 6'(a + b);
    endfunction : ring_add

    function automatic logic chop_sel(input logic [1:0] field, input logic a12);
        return (field == drb_pkg::BL_FIX4) || ((field == drb_pkg::BL_OTF) && !a12);
    endfunction : chop_sel

    // registers
    logic [1:0]  bl_field;
    logic        pre2;
    logic [5:0]  cas_lat;
    logic [5:0]  add_lat;
    logic [7:0]  bank_open;
    logic        refused;
    logic        underrun;
    logic [15:0] served;

    // schedule ring, one slot per ck cycle
    drb_pkg::drb_slot_t ring [0:drb_pkg::RING_DEPTH-1];
    logic [5:0]  tick;

    // driver state
    drb_pkg::drb_drv_t state;
    logic [3:0]  beats_left;
    logic        cur_ap;
    logic [2:0]  cur_bank;

    wire         hit_mode   = (reg_addr == drb_pkg::REG_MODE);
    wire         hit_lat    = (reg_addr == drb_pkg::REG_LAT);
    wire         hit_bank   = (reg_addr == drb_pkg::REG_BANK);
    wire         hit_status = (reg_addr == drb_pkg::REG_STATUS);
    wire         hit_count  = (reg_addr == drb_pkg::REG_COUNT);

    wire [5:0]   read_lat   = ring_add(add_lat, cas_lat);
    wire         cmd_seen   = ck_rise & ~rd_n_s;
    wire         cmd_take   = cmd_seen & lock_s;
    wire         cmd_refuse = cmd_seen & ~lock_s;
    wire [5:0]   due_idx    = ring_add(tick, read_lat);

    drb_pkg::drb_slot_t new_slot;
    assign new_slot.valid   = 1'b1;
    assign new_slot.chop    = chop_sel(bl_field, a12_s);
    assign new_slot.autopre = a10_s;
    assign new_slot.bank    = bank_s;

    drb_pkg::drb_slot_t cur_slot;
    drb_pkg::drb_slot_t look1;
    drb_pkg::drb_slot_t look2;
    assign cur_slot = ring[tick];
    assign look1    = ring[ring_add(tick, 6'h01)];
    assign look2    = ring[ring_add(tick, 6'h02)];

    wire  mid_burst  = (state == drb_pkg::DRV_DATA);
    wire  start      = ck_rise & ~mid_burst & cur_slot.valid;
    wire  need_pre   = look1.valid | (pre2 & look2.valid);
    wire  finishing  = ck_rise & (state == drb_pkg::DRV_POST);
    wire  rise_beat  = ck_rise & (start | mid_burst);
    wire  fall_beat  = ck_fall & mid_burst;
    wire  beat       = rise_beat | fall_beat;
    wire  [7:0] clear_mask = (finishing & cur_ap) ? (8'h01 << cur_bank) : 8'h00;
    wire  [3:0] burst_len  = cur_slot.chop ? drb_pkg::BEATS_BC4 : drb_pkg::BEATS_BL8;

    assign buf_pop = beat & buf_valid;

    wire  clr_refuse = reg_wr & hit_status & reg_wdata[drb_pkg::ST_REFUSE];
    wire  clr_under  = reg_wr & hit_status & reg_wdata[drb_pkg::ST_UNDER];

    wire [31:0] status_word = {28'h0000000, underrun, refused,
                               (state != drb_pkg::DRV_IDLE), lock_s};
    wire [31:0] read_mux =
        hit_mode   ? {29'h0, pre2, bl_field} :
        hit_lat    ? {18'h0, add_lat, 2'h0, cas_lat} :
        hit_bank   ? {24'h0, bank_open} :
        hit_status ? status_word :
        hit_count  ? {16'h0, served} : 32'h0000_0000;

    // register port
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bl_field <= drb_pkg::BL_RST;
            pre2     <= drb_pkg::PRE2_RST;
            cas_lat  <= drb_pkg::CL_RST;
            add_lat  <= drb_pkg::AL_RST;
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (reg_wr && hit_mode) begin
                bl_field <= reg_wdata[drb_pkg::MODE_BL_LSB +: 2];
                pre2     <= reg_wdata[drb_pkg::MODE_PRE2];
            end
            if (reg_wr && hit_lat) begin
                cas_lat <= reg_wdata[drb_pkg::LAT_CL_LSB +: 6];
                add_lat <= reg_wdata[drb_pkg::LAT_AL_LSB +: 6];
            end
            reg_rdata <= reg_rd ? read_mux : 32'h0000_0000;
        end
    end

    // bank state and sticky flags, hardware set wins over clear
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bank_open <= drb_pkg::BANK_RST;
            refused   <= 1'b0;
            underrun  <= 1'b0;
            served    <= 16'h0000;
        end else begin
            bank_open <= ((reg_wr && hit_bank) ? reg_wdata[7:0] : bank_open) & ~clear_mask;
            refused   <= cmd_refuse | (refused & ~clr_refuse);
            underrun  <= (beat & ~buf_valid) | (underrun & ~clr_under);
            if (finishing) begin
                served <= 16'(served + 16'h0001);
            end
        end
    end

    // edge detector and schedule ring
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ck_d <= 1'b0;
            tick <= 6'h00;
            for (int i = 0; i < drb_pkg::RING_DEPTH; i++) begin
                ring[i] <= '0;
            end
        end else begin
            ck_d <= ck_s;
            if (ck_rise) begin
                ring[tick] <= '0;
                tick       <= ring_add(tick, 6'h01);
            end
            if (cmd_take) begin
                ring[due_idx] <= new_slot;
            end
        end
    end

    // strobe and data driver
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state      <= drb_pkg::DRV_IDLE;
            beats_left <= 4'h0;
            cur_ap     <= 1'b0;
            cur_bank   <= 3'h0;
            dq_out     <= 16'h0000;
            dq_oe_n    <= 1'b1;
            dqs_out    <= 1'b0;
            dqs_oe_n   <= 1'b1;
        end else begin
            if (beat && buf_valid) begin
                dq_out <= buf_data;
            end
            if (ck_rise) begin
                if (mid_burst) begin
                    dqs_out    <= 1'b1;
                    beats_left <= 4'(beats_left - 4'h1);
                end else if (cur_slot.valid) begin
                    state      <= drb_pkg::DRV_DATA;
                    beats_left <= 4'(burst_len - 4'h1);
                    cur_ap     <= cur_slot.autopre;
                    cur_bank   <= cur_slot.bank;
                    dqs_out    <= 1'b1;
                    dqs_oe_n   <= 1'b0;
                    dq_oe_n    <= 1'b0;
                end else if (need_pre) begin
                    state    <= drb_pkg::DRV_PRE;
                    dqs_out  <= 1'b0;
                    dqs_oe_n <= 1'b0;
                    dq_oe_n  <= 1'b1;
                end else begin
                    state    <= drb_pkg::DRV_IDLE;
                    dqs_out  <= 1'b0;
                    dqs_oe_n <= 1'b1;
                    dq_oe_n  <= 1'b1;
                end
            end else if (fall_beat) begin
                dqs_out    <= 1'b0;
                beats_left <= 4'(beats_left - 4'h1);
                if (beats_left == 4'h1) begin
                    state <= drb_pkg::DRV_POST;
                end
            end
        end
    end
endmodule : drb_read_path
`default_nettype wire

// file: dv/drb_read_path_props.sv
// Purpose: pin-level checks of the read burst path
// Assumes: single core_clk domain, synchronous rstn
// Notes:   bound onto the top module below
`default_nettype none
module drb_read_path_props (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe_n,
    input wire logic        dqs_out,
    input wire logic        dqs_oe_n,
    input wire logic        beat_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_dq_with_dqs: assert property (!dq_oe_n |-> !dqs_oe_n)
        else $error("dq driven without dqs");
    a_first_high: assert property ($fell(dq_oe_n) |-> dqs_out)
        else $error("first beat strobe low");
    a_pre_low: assert property ($fell(dqs_oe_n) |-> !dqs_out && dq_oe_n)
        else $error("preamble not low");
    a_pre_lead: assert property ($fell(dq_oe_n) |-> !$past(dqs_oe_n, 4))
        else $error("preamble too short");
    a_release_both: assert property ($rose(dq_oe_n) |-> $rose(dqs_oe_n))
        else $error("dq and dqs released apart");
    a_post_low: assert property ($rose(dqs_oe_n) |-> !$past(dqs_out) && !$past(dqs_out, 4))
        else $error("postamble not low");
    a_dqs_in_data: assert property ($changed(dqs_out) |-> !dq_oe_n)
        else $error("strobe moves outside data");
    a_beat_on_edge: assert property (!dq_oe_n && $changed(dq_out) |-> $changed(dqs_out))
        else $error("beat without strobe edge");
    a_burst_min: assert property ($fell(dq_oe_n) |=> !dq_oe_n [*8])
        else $error("burst too short");
    c_burst: cover property ($rose(dq_oe_n));
    c_pre: cover property ($fell(dqs_oe_n));
    c_full: cover property (!beat_ready);
endmodule : drb_read_path_props
bind drb_read_path drb_read_path_props i_props (.core_clk(core_clk), .rstn(rstn), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .beat_ready(beat_ready));
`default_nettype wire

// file: dv/drb_ctrl_model.sv
// Purpose: controller side: free ck, read commands, burst timing capture
// Assumes: ck period 125 ns, pins change at ck fall
// Notes:   ck rises counted from the command rise
`default_nettype none
module drb_ctrl_model (
    output logic       ck,
    output logic       rd_cmd_n,
    output logic       addr_a10,
    output logic       addr_a12,
    output logic [2:0] bank_addr,
    input  wire logic  dq_oe_n,
    input  wire logic  dqs_oe_n,
    input  wire logic  dqs_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int      cnt = 0, pre_at, first_at, rel_at, nb, post, bursts = 0;
    bit      armed = 0;
    realtime t_fall;
    event    done_ev;
    initial begin
        ck = 1'b0;
        rd_cmd_n = 1'b1;
        {addr_a10, addr_a12, bank_addr} = 5'h00;
    end
    always #62.5 ck = ~ck;
    always @(posedge ck) cnt <= rd_cmd_n ? cnt + 1 : 0;
    // reads only, so write preamble latency never arises
    task automatic issue(input logic a10, input logic a12, input logic [2:0] ba);
        @(negedge ck);
        armed = 1;
        rd_cmd_n <= 1'b0;
        {addr_a10, addr_a12, bank_addr} <= {a10, a12, ba};
        @(negedge ck);
        rd_cmd_n <= 1'b1;
        {addr_a10, addr_a12, bank_addr} <= ~{a10, a12, ba};
    endtask : issue
    always @(negedge dqs_oe_n) begin
        pre_at = cnt;
        nb = 0;
    end
    always @(negedge dq_oe_n) first_at = cnt;
    always @(dqs_out) if (!dqs_oe_n) nb++;
    always @(negedge dqs_out) t_fall = $realtime;
    always @(posedge dq_oe_n) if (armed) begin
        rel_at = cnt;
        post = $rtoi($realtime - t_fall);
        bursts++;
        armed = 0;
        -> done_ev;
    end
endmodule : drb_ctrl_model
`default_nettype wire

// file: dv/drb_read_path_tb.sv
// Purpose: self-checking bench of the read burst path
// Assumes: beat source stalls at random, ck free running
// Notes:   beats and burst timing compared through queues
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module drb_read_path_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct { int pre, first, rel, nb; } drb_exp_t;
    localparam logic [4:0] T_A12 = 5'h0C, T_A10 = 5'h0A, T_PRE2 = 5'h06;
    logic        core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, dll_locked = 1, beat_valid = 0;
    logic        beat_ready, dq_oe_n, dqs_out, dqs_oe_n, prev_dqs = 0, a10, a12, p2, b8;
    logic        ck, rd_cmd_n, addr_a10, addr_a12;
    logic [2:0]  bank_addr;
    logic [1:0]  bl;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [15:0] dq_out, beat_data = 0, rnd = 16'h0039, eb;
    logic [15:0] beat_q[$];
    drb_exp_t    exp_q[$], e;
    int          miscompares = 0, num_checks = 0, cyc = 0, al, rl, k;

    always #4 core_clk = ~core_clk;

    drb_read_path i_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ck(ck), .rd_cmd_n(rd_cmd_n),
        .addr_a10(addr_a10), .addr_a12(addr_a12), .bank_addr(bank_addr), .dll_locked(dll_locked),
        .dq_in(dq_oe_n ? 16'hFFFF : dq_out), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dqs_in(dqs_oe_n | dqs_out), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n),
        .beat_valid(beat_valid), .beat_ready(beat_ready), .beat_data(beat_data));
    drb_ctrl_model i_ctrl (.ck(ck), .rd_cmd_n(rd_cmd_n), .addr_a10(addr_a10), .addr_a12(addr_a12),
        .bank_addr(bank_addr), .dq_oe_n(dq_oe_n), .dqs_oe_n(dqs_oe_n), .dqs_out(dqs_out));

    function automatic logic [15:0] drb_lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : drb_lfsr

    // beat source: note each accepted word, stall at random
    always @(posedge core_clk) if (rstn) begin
        if (beat_valid && beat_ready) beat_q.push_back(beat_data);
        if (!beat_valid || beat_ready) begin
            rnd = drb_lfsr(rnd);
            beat_valid <= rnd[3] | rnd[9];
            beat_data  <= rnd;
        end
    end

    always @(posedge core_clk) begin
        prev_dqs <= dqs_out;
        if (rstn && dq_oe_n === 1'b0 && dqs_out !== prev_dqs) begin
            eb = beat_q.pop_front();
            `CHK("beat", eb, dq_out)
        end
    end

    always @(i_ctrl.done_ev) begin
        e = exp_q.pop_front();
        `CHK("pre_at", e.pre, i_ctrl.pre_at)
        `CHK("first_at", e.first, i_ctrl.first_at)
        `CHK("rel_at", e.rel, i_ctrl.rel_at)
        `CHK("beats", e.nb, i_ctrl.nb)
        `CHK("post", 1'b1, i_ctrl.post inside {[50:75]})
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(posedge core_clk);
        `CHK("reg", x, reg_rdata)
    endtask : rd_chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 10000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        rd_chk(drb_pkg::REG_MODE, 32'h0);
        rd_chk(drb_pkg::REG_LAT, 32'h0000000B);
        rd_chk(drb_pkg::REG_BANK, 32'h0);
        rd_chk(drb_pkg::REG_STATUS, 32'h1);
        wr(8'h14, 32'hFFFFFFFF);
        rd_chk(8'h14, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            bl = (i == 0) ? drb_pkg::BL_FIX8 : (i == 3) ? drb_pkg::BL_FIX4 : (i == 4) ? 2'h3 : drb_pkg::BL_OTF;
            a12 = T_A12[i];
            a10 = T_A10[i];
            p2 = T_PRE2[i];
            al = (i == 2 || i == 3) ? 3 : 0;
            rl = al + (al ? 4 : 5);
            b8 = (bl == drb_pkg::BL_FIX4) ? 1'b0 : (bl == drb_pkg::BL_OTF) ? a12 : 1'b1;
            wr(drb_pkg::REG_MODE, {29'h0, p2, bl});
            wr(drb_pkg::REG_LAT, 32'(al * 256 + rl - al));
            wr(drb_pkg::REG_BANK, 32'hFF);
            exp_q.push_back('{rl - 1 - p2, rl, rl + (b8 ? 4 : 2), b8 ? 8 : 4});
            i_ctrl.issue(a10, a12, 3'(i + 1));
            for (k = 0; k < 800 && i_ctrl.armed; k++) @(posedge core_clk);
            rd_chk(drb_pkg::REG_BANK, a10 ? 32'hFF & ~(32'h1 << (i + 1)) : 32'hFF);
            rd_chk(drb_pkg::REG_COUNT, 32'(i + 1));
            $display("test burst %0d done", i);
        end
        // unlocked dll: read must leave pins and bank alone
        dll_locked <= 1'b0;
        repeat (20) @(posedge core_clk);
        wr(drb_pkg::REG_BANK, 32'hFF);
        i_ctrl.issue(1'b1, 1'b1, 3'h0);
        repeat (300) @(posedge core_clk);
        `CHK("bursts", 5, i_ctrl.bursts)
        rd_chk(drb_pkg::REG_STATUS, 32'h4);
        rd_chk(drb_pkg::REG_BANK, 32'hFF);
        dll_locked <= 1'b1;
        wr(drb_pkg::REG_STATUS, 32'hC);
        repeat (20) @(posedge core_clk);
        rd_chk(drb_pkg::REG_STATUS, 32'h1);
        $display("test refuse done");
        `CHK("pending", 0, exp_q.size())
        report_and_stop();
    end
endmodule : drb_read_path_tb
`default_nettype wire
